// *** rtl/rsc_top.sv ***
`timescale 1ns/1ps
`include "rsc_defines.svh"
module rsc_top (
   input wire logic ref_clk_in, // 40 MHz system clock
   input wire logic rst_in, // Power-on reset, sync, high
   input wire logic sub_tick_in, // Sub-clock period pulse
   input wire logic reset_pin_n_in, // Shared pin level
   input wire logic supply_low_in, // Supply within 0.9V..threshold
   input wire logic sleep_in, // Sleep or idle mode
   input wire logic wdt_cfg_bad_in, // Watchdog control code invalid
   input wire logic wdt_timeout_in, // Watchdog time-out warm reset
   input wire logic awvalid, // AXI write address valid
   output logic awready, // AXI write address ready
   input wire logic [7:0] awaddr, // AXI write address
   input wire logic wvalid, // AXI write data valid
   output logic wready, // AXI write data ready
   input wire logic [31:0] wdata, // AXI write data
   input wire logic [3:0] wstrb, // AXI write strobes
   output logic bvalid, // AXI write response valid
   input wire logic bready, // AXI write response ready
   output logic [1:0] bresp, // AXI write response
   input wire logic arvalid, // AXI read address valid
   output logic arready, // AXI read address ready
   input wire logic [7:0] araddr, // AXI read address
   output logic rvalid, // AXI read valid
   input wire logic rready, // AXI read ready
   output logic [31:0] rdata, // AXI read data
   output logic [1:0] rresp, // AXI read response
   output logic dev_reset_out, // Device reset, high while held
   output logic pc_clear_out, // Program counter clear pulse
   output logic pin_is_reset_out, // Pin owns reset role
   output logic [7:0] lv_threshold_out, // Active threshold code
   output logic [7:0] port_preset_out // Port data/control preset
);
   import rsc_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] pin_sel_r;
   logic [7:0] vsel_r;
   logic [1:0] dipw_r;
   logic [3:0] cause_r;
   rsc_state_t state_r;
   rsc_kind_t kind_r;
   logic [15:0] cnt_r;
   logic aw_hold_r;
   logic w_hold_r;
   rsc_wreq_t wreq_r;
   logic pin_bad;
   logic v_bad;
   logic lv_trip;
   logic lv_en;
   logic wr_go;
   logic wr_cause;
   logic [3:0] sets;
   logic ext_low;
   rsc_rrsp_t rd;

   // ----------------------------------------
   // Code decode
   // ----------------------------------------
   assign pin_bad = (pin_sel_r != `RSC_PIN_IO) && (pin_sel_r != `RSC_PIN_RESET);
   assign v_bad = (vsel_r != `RSC_V_1V7) && (vsel_r != `RSC_V_1V9) &&
      (vsel_r != `RSC_V_2V55) && (vsel_r != `RSC_V_3V15) &&
      (vsel_r != `RSC_V_3V8) && (vsel_r != `RSC_V_OFF);
   assign lv_en = (vsel_r != `RSC_V_OFF) && !v_bad && !sleep_in;
   assign ext_low = (pin_sel_r == `RSC_PIN_RESET) && !reset_pin_n_in;

   rsc_dip_filter u_dip (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .sub_tick_in(sub_tick_in),
      .dip_in(supply_low_in),
      .enable_in(lv_en),
      .width_in(dipw_r),
      .trip_out(lv_trip)
   );

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign wr_go = aw_hold_r && w_hold_r && !bvalid;

   // Accept address and data in either order, answer after both
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         wreq_r <= '0;
      end else begin
         awready <= !aw_hold_r && !awready && awvalid;
         wready <= !w_hold_r && !wready && wvalid;
         if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            wreq_r.addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wreq_r.data <= wdata;
            wreq_r.strb <= wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wreq_r.addr == `RSC_ADDR_PIN_SEL || wreq_r.addr == `RSC_ADDR_CAUSE ||
               wreq_r.addr == `RSC_ADDR_VSEL || wreq_r.addr == `RSC_ADDR_DIPW ||
               wreq_r.addr == `RSC_ADDR_STATUS) ? 2'b00 : 2'b10;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   assign wr_cause = wr_go && wreq_r.strb[0] && wreq_r.addr == `RSC_ADDR_CAUSE;

   // ----------------------------------------
   // Pin function select register
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_sel_r <= `RSC_PIN_IO;
      end else if (state_r == RSC_HOLD && kind_r != RSC_K_WDTTO) begin
         pin_sel_r <= `RSC_PIN_IO;
      end else if (wr_go && wreq_r.strb[0] && wreq_r.addr == `RSC_ADDR_PIN_SEL) begin
         pin_sel_r <= wreq_r.data[7:0];
      end
   end

   // ----------------------------------------
   // Voltage select and dip width registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         vsel_r <= `RSC_V_1V7;
         dipw_r <= `RSC_DIPW_RST;
      end else begin
         if (state_r == RSC_HOLD && kind_r == RSC_K_SWV) begin
            vsel_r <= `RSC_V_1V7;
         end else if (wr_go && wreq_r.strb[0] && wreq_r.addr == `RSC_ADDR_VSEL) begin
            vsel_r <= wreq_r.data[7:0];
         end
         if (wr_go && wreq_r.strb[0] && wreq_r.addr == `RSC_ADDR_DIPW) begin
            dipw_r <= wreq_r.data[1:0];
         end
      end
   end
   // A genuine undervoltage reset never writes vsel_r

   // ----------------------------------------
   // Reset cause flags
   // ----------------------------------------
   always_comb begin
      sets = 4'h0;
      sets[`RSC_F_PIN] = state_r == RSC_PEND && kind_r == RSC_K_SWPIN && cnt_r == 16'd0;
      sets[`RSC_F_VREG] = state_r == RSC_PEND && kind_r == RSC_K_SWV && cnt_r == 16'd0;
      sets[`RSC_F_WDT] = state_r == RSC_PEND && kind_r == RSC_K_SWWDT && cnt_r == 16'd0;
      sets[`RSC_F_LV] = lv_trip && state_r == RSC_RUN;
   end

   // Software writes may only clear; hardware set wins
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cause_r <= 4'h0;
      end else if (wr_cause) begin
         cause_r <= (cause_r & wreq_r.data[3:0]) | sets;
      end else begin
         cause_r <= cause_r | sets;
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_r <= RSC_RUN;
         kind_r <= RSC_K_NONE;
         cnt_r <= 16'd0;
      end else begin
         case (state_r)
            RSC_RUN: begin
               if (ext_low) begin
                  state_r <= RSC_HOLD;
                  kind_r <= RSC_K_PIN;
               end else if (lv_trip) begin
                  state_r <= RSC_HOLD;
                  kind_r <= RSC_K_LV;
               end else if (wdt_timeout_in) begin
                  state_r <= RSC_HOLD;
                  kind_r <= RSC_K_WDTTO;
               end else if (pin_bad || v_bad || wdt_cfg_bad_in) begin
                  state_r <= RSC_PEND;
                  kind_r <= pin_bad ? RSC_K_SWPIN : (v_bad ? RSC_K_SWV : RSC_K_SWWDT);
                  cnt_r <= 16'(`RSC_SW_DELAY_CYC - 1);
               end
            end
            RSC_PEND: begin
               if (cnt_r == 16'd0) begin
                  state_r <= RSC_HOLD;
               end else begin
                  cnt_r <= cnt_r - 16'd1;
               end
            end
            RSC_HOLD: begin
               state_r <= RSC_REL;
               cnt_r <= 16'(`RSC_PIN_DELAY_CYC - 1);
            end
            default: begin
               if (ext_low || (kind_r == RSC_K_PIN && !reset_pin_n_in)) begin
                  cnt_r <= 16'(`RSC_PIN_DELAY_CYC - 1);
               end else if (cnt_r == 16'd0) begin
                  state_r <= RSC_RUN;
                  kind_r <= RSC_K_NONE;
               end else begin
                  cnt_r <= cnt_r - 16'd1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Device-facing outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dev_reset_out <= 1'b1;
         pc_clear_out <= 1'b0;
         pin_is_reset_out <= 1'b0;
         lv_threshold_out <= `RSC_V_1V7;
         port_preset_out <= `RSC_PORT_RST;
      end else begin
         dev_reset_out <= state_r == RSC_HOLD || state_r == RSC_REL || ext_low;
         pc_clear_out <= state_r == RSC_HOLD;
         pin_is_reset_out <= pin_sel_r == `RSC_PIN_RESET;
         lv_threshold_out <= lv_en ? vsel_r : `RSC_V_OFF;
         port_preset_out <= `RSC_PORT_RST;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always_comb begin
      rd.data = 32'h0000_0000;
      rd.resp = 2'b00;
      if (araddr == `RSC_ADDR_PIN_SEL) begin
         rd.data[7:0] = pin_sel_r;
      end else if (araddr == `RSC_ADDR_CAUSE) begin
         rd.data[3:0] = cause_r;
      end else if (araddr == `RSC_ADDR_VSEL) begin
         rd.data[7:0] = vsel_r;
      end else if (araddr == `RSC_ADDR_DIPW) begin
         rd.data[1:0] = dipw_r;
      end else if (araddr == `RSC_ADDR_STATUS) begin
         rd.data[4:0] = {lv_en, kind_r, state_r != RSC_RUN};
      end else begin
         rd.resp = 2'b10;
      end
   end

   // Take address, answer next cycle, hold until rready
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else begin
         arready <= !arready && !rvalid && arvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd.data;
            rresp <= rd.resp;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : rsc_top

// *** rtl/rsc_defines.svh ***
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RSC_ADDR_PIN_SEL 8'h00
`define RSC_ADDR_CAUSE 8'h04
`define RSC_ADDR_VSEL 8'h08
`define RSC_ADDR_DIPW 8'h0C
`define RSC_ADDR_STATUS 8'h10

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define RSC_PIN_IO 8'h55
`define RSC_PIN_RESET 8'hAA
`define RSC_V_1V7 8'h66
`define RSC_V_1V9 8'h55
`define RSC_V_2V55 8'h33
`define RSC_V_3V15 8'h99
`define RSC_V_3V8 8'hAA
`define RSC_V_OFF 8'hF0
`define RSC_DIPW_RST 2'b01
`define RSC_PORT_RST 8'hFF

// ----------------------------------------
// Cause flag bit positions
// ----------------------------------------
`define RSC_F_WDT 0
`define RSC_F_VREG 1
`define RSC_F_LV 2
`define RSC_F_PIN 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_SW_DELAY_NS 1000
`define RSC_PIN_DELAY_NS 1000
`define RSC_CLK_NS 25
`define RSC_SW_DELAY_CYC ((`RSC_SW_DELAY_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_PIN_DELAY_CYC ((`RSC_PIN_DELAY_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_DIP_0 8'd8
`define RSC_DIP_1 8'd32
`define RSC_DIP_2 8'd64
`define RSC_DIP_3 8'd128

`endif

// *** rtl/rsc_pkg.sv ***
package rsc_pkg;
   // Reset sequencer states, Gray along idle->pending->hold->release
   typedef enum logic [1:0] {
      RSC_RUN = 2'b00,
      RSC_PEND = 2'b01,
      RSC_HOLD = 2'b11,
      RSC_REL = 2'b10
   } rsc_state_t;

   // Reset kinds
   typedef enum logic [2:0] {
      RSC_K_NONE = 3'd0,
      RSC_K_PIN = 3'd1,
      RSC_K_LV = 3'd2,
      RSC_K_SWPIN = 3'd3,
      RSC_K_SWV = 3'd4,
      RSC_K_SWWDT = 3'd5,
      RSC_K_WDTTO = 3'd6
   } rsc_kind_t;

   // AXI4-Lite channel bundles
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } rsc_wreq_t;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } rsc_rrsp_t;
endpackage : rsc_pkg

// *** rtl/rsc_dip_filter.sv ***
`timescale 1ns/1ps
`include "rsc_defines.svh"
module rsc_dip_filter (
   input wire logic ref_clk_in, // System clock
   input wire logic rst_in, // Sync reset
   input wire logic sub_tick_in, // One pulse per sub-clock period
   input wire logic dip_in, // Supply within low band
   input wire logic enable_in, // Detection enabled
   input wire logic [1:0] width_in, // Dip width code
   output logic trip_out // One-cycle trip pulse
);
   import rsc_pkg::*;

   logic [7:0] cnt_r;
   logic [7:0] limit;

   // Width code to sub-clock count
   always_comb begin
      case (width_in)
         2'b00: limit = `RSC_DIP_0;
         2'b01: limit = `RSC_DIP_1;
         2'b10: limit = `RSC_DIP_2;
         default: limit = `RSC_DIP_3;
      endcase
   end

   // Count sub periods of a continuous dip; short dips restart it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !dip_in || !enable_in) begin
         cnt_r <= 8'h00;
         trip_out <= 1'b0;
      end else begin
         trip_out <= 1'b0;
         if (sub_tick_in && cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'd1;
            if (cnt_r + 8'd1 == limit) begin
               trip_out <= 1'b1;
            end
         end
      end
   end
endmodule : rsc_dip_filter

// *** verification/rsc_top_sva.sv ***
`timescale 1ns/1ps
module rsc_top_sva (
   input wire logic ref_clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic reset_pin_n_in, // Pin level
   input wire logic rvalid, // Read valid
   input wire logic rready, // Read ready
   input wire logic [31:0] rdata, // Read data
   input wire logic dev_reset_out, // Device reset
   input wire logic pc_clear_out, // PC clear
   input wire logic pin_is_reset_out, // Pin role
   input wire logic [7:0] lv_threshold_out, // Threshold
   input wire logic [7:0] port_preset_out // Port preset
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_PRESET: assert property (port_preset_out == 8'hFF)
      else $error("Port preset not all ones");
   AST_POR_VALUES: assert property ($fell(rst_in) |->
      !pin_is_reset_out && lv_threshold_out == 8'h66) else $error("Bad power-on values");
   AST_THR_LEGAL: assert property (lv_threshold_out inside
      {8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0}) else $error("Illegal threshold code");
   AST_PIN_RESET: assert property ($fell(reset_pin_n_in) && pin_is_reset_out
      |-> ##[1:3] dev_reset_out) else $error("Pin low gave no reset");
   AST_PIN_HOLD: assert property (dev_reset_out && pin_is_reset_out && !reset_pin_n_in
      |=> dev_reset_out) else $error("Reset dropped while pin low");
   AST_PIN_DELAY: assert property ($rose(reset_pin_n_in) && dev_reset_out
      |=> dev_reset_out [*8]) else $error("Release delay too short");
   AST_PC_IN_RST: assert property (pc_clear_out |-> ##[0:1] dev_reset_out)
      else $error("PC clear outside reset");
   AST_PC_PULSE: assert property (pc_clear_out |=> !pc_clear_out)
      else $error("PC clear longer than a cycle");
   AST_UPPER_ZERO: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("Upper read bits not zero");
   // Main scenarios seen
   COV_PC: cover property (pc_clear_out);
   COV_PIN: cover property (dev_reset_out && !reset_pin_n_in);
   COV_READ: cover property (rvalid && rready);
endmodule : rsc_top_sva

bind rsc_top rsc_top_sva u_sva (.ref_clk_in, .rst_in, .reset_pin_n_in, .rvalid, .rready,
   .rdata, .dev_reset_out, .pc_clear_out, .pin_is_reset_out, .lv_threshold_out,
   .port_preset_out);

// *** verification/rsc_far_model.sv ***
`timescale 1ns/1ps
module rsc_far_model #(
   parameter int SUB_DIV = 4,
   parameter int RISE_CYC = 3
) (
   input wire logic ref_clk_in, // Clock
   input wire logic pull_low_in, // Hold pin low
   input wire logic dip_in, // Supply dip wanted
   output logic sub_tick_out, // Sub period tick
   output logic reset_pin_n_out, // Pin level
   output logic supply_low_out // Supply in low band
);
   int div_r = 0;
   int rise_r = 0;
   logic tick_r = 1'b0;
   logic pin_r = 1'b1;
   logic low_r = 1'b0;
   assign sub_tick_out = tick_r;
   assign reset_pin_n_out = pin_r;
   assign supply_low_out = low_r;
   // Free running sub clock ticks
   always @(posedge ref_clk_in) begin
      div_r <= (div_r == SUB_DIV - 1) ? 0 : div_r + 1;
      tick_r <= (div_r == SUB_DIV - 1);
   end
   // Pull-up with slow RC rise after release
   always @(posedge ref_clk_in) begin
      if (pull_low_in) begin
         rise_r <= RISE_CYC;
         pin_r <= 1'b0;
      end else if (rise_r != 0) begin
         rise_r <= rise_r - 1;
      end else begin
         pin_r <= 1'b1;
      end
   end
   // Supply monitor follows the dip request
   always @(posedge ref_clk_in) begin
      low_r <= dip_in;
   end
endmodule : rsc_far_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   import rsc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in, sub_tick_in, reset_pin_n_in, supply_low_in, sleep_in, wdt_cfg_bad_in;
   logic wdt_timeout_in, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, dev_reset_out, pc_clear_out, pin_is_reset_out, pull_low, dip_on;
   logic [7:0] awaddr, araddr, lv_threshold_out, port_preset_out;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, last_resp;
   logic rst_q = 1'b0;
   int n_errors = 0;
   int compares = 0;
   int n_rst = 0;
   int n_pc = 0;
   int n;
   // Clock at 40 MHz
   always #12.5 ref_clk_in = ~ref_clk_in;
   rsc_top u_dut (.ref_clk_in, .rst_in, .sub_tick_in, .reset_pin_n_in, .supply_low_in,
      .sleep_in, .wdt_cfg_bad_in, .wdt_timeout_in, .awvalid, .awready, .awaddr, .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .rvalid, .rready, .rdata, .rresp, .dev_reset_out, .pc_clear_out, .pin_is_reset_out,
      .lv_threshold_out, .port_preset_out);
   rsc_far_model #(.SUB_DIV(4), .RISE_CYC(3)) u_far (.ref_clk_in, .pull_low_in(pull_low),
      .dip_in(dip_on), .sub_tick_out(sub_tick_in), .reset_pin_n_out(reset_pin_n_in),
      .supply_low_out(supply_low_in));
   // Count reset entries and PC clear pulses
   always @(posedge ref_clk_in) begin
      if (dev_reset_out === 1'b1 && rst_q !== 1'b1) n_rst++;
      if (pc_clear_out === 1'b1) n_pc++;
      rst_q <= dev_reset_out;
   end
   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hF; bready <= 1'b1;
      fork
         begin do @(posedge ref_clk_in); while (awready !== 1'b1); awvalid <= 1'b0; end
         begin do @(posedge ref_clk_in); while (wready !== 1'b1); wvalid <= 1'b0; end
      join
      do @(posedge ref_clk_in); while (bvalid !== 1'b1);
      bready <= 1'b0;
      last_resp = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do @(posedge ref_clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk_in); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      last_resp = rresp;
   endtask : rd
   task automatic idle();
      repeat (3) @(posedge ref_clk_in);
      while (dev_reset_out !== 1'b0) @(posedge ref_clk_in);
   endtask : idle
   task automatic meas();
      n = 0;
      while (dev_reset_out !== 1'b1 && n < 200) begin @(posedge ref_clk_in); n++; end
      idle();
   endtask : meas
   task automatic dip(input int c);
      dip_on <= 1'b1;
      repeat (c) @(posedge ref_clk_in);
      dip_on <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
   endtask : dip
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_por();
      rd(8'h00); `CHK(d, 32'h0000_0055)
      rd(8'h08); `CHK(d, 32'h0000_0066)
      rd(8'h04); `CHK(d, 32'h0000_0000)
      rd(8'h0C); `CHK(d, 32'h0000_0001)
      rd(8'h14); `CHK(last_resp, 2'b10)
      wr(8'h14, 32'h0000_0000); `CHK(last_resp, 2'b10)
      wr(8'h0C, 32'h0000_0001); `CHK(last_resp, 2'b00)
      `CHK(port_preset_out, 8'hFF)
   endtask : t_por
   task automatic t_vcodes();
      logic [7:0] c [6] = '{8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0, 8'h66};
      foreach (c[i]) begin
         wr(8'h08, {24'h00_0000, c[i]});
         rd(8'h08); `CHK(d[7:0], c[i])
         `CHK(lv_threshold_out, c[i])
      end
   endtask : t_vcodes
   task automatic t_badpin();
      wr(8'h00, 32'h0000_005A);
      meas(); `CHK(n inside {[30:50]}, 1'b1)
      rd(8'h04); `CHK(d, 32'h0000_0008)
      wr(8'h04, 32'h0000_0000);
      wr(8'h04, 32'h0000_00FF);
      rd(8'h04); `CHK(d, 32'h0000_0000)
   endtask : t_badpin
   task automatic t_badvolt();
      wr(8'h00, 32'h0000_00AA);
      wr(8'h08, 32'h0000_0012);
      meas(); `CHK(n inside {[30:50]}, 1'b1)
      rd(8'h08); `CHK(d, 32'h0000_0066)
      rd(8'h00); `CHK(d, 32'h0000_0055)
      rd(8'h04); `CHK(d, 32'h0000_0002)
      wr(8'h04, 32'h0000_0000);
   endtask : t_badvolt
   task automatic t_pin();
      int p;
      wr(8'h00, 32'h0000_00AA);
      @(posedge ref_clk_in);
      `CHK(pin_is_reset_out, 1'b1)
      p = n_pc;
      pull_low <= 1'b1;
      repeat (100) @(posedge ref_clk_in);
      `CHK(dev_reset_out, 1'b1)
      `CHK(n_pc > p, 1'b1)
      pull_low <= 1'b0;
      repeat (20) @(posedge ref_clk_in);
      `CHK(dev_reset_out, 1'b1)
      idle();
      rd(8'h00); `CHK(d, 32'h0000_0055)
   endtask : t_pin
   task automatic t_dip();
      int r;
      wr(8'h0C, 32'h0000_0000);
      wr(8'h08, 32'h0000_0055);
      r = n_rst;
      dip(20);
      sleep_in <= 1'b1;
      dip(80);
      sleep_in <= 1'b0;
      wr(8'h08, 32'h0000_00F0);
      dip(80);
      `CHK(n_rst - r, 0)
      wr(8'h08, 32'h0000_0055);
      dip(60);
      idle();
      `CHK(n_rst - r, 1)
      rd(8'h04); `CHK(d, 32'h0000_0004)
      rd(8'h08); `CHK(d, 32'h0000_0055)
      wr(8'h04, 32'h0000_0000);
   endtask : t_dip
   task automatic t_wdt();
      wr(8'h00, 32'h0000_00AA);
      wdt_cfg_bad_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      wdt_cfg_bad_in <= 1'b0;
      meas(); `CHK(n inside {[28:50]}, 1'b1)
      rd(8'h04); `CHK(d, 32'h0000_0001)
      rd(8'h00); `CHK(d, 32'h0000_0055)
      wr(8'h00, 32'h0000_00AA);
      wdt_timeout_in <= 1'b1;
      @(posedge ref_clk_in);
      wdt_timeout_in <= 1'b0;
      idle();
      rd(8'h00); `CHK(d, 32'h0000_00AA)
   endtask : t_wdt
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      rst_in = 1'b1; sleep_in = 1'b0; wdt_cfg_bad_in = 1'b0; wdt_timeout_in = 1'b0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0;
      pull_low = 1'b0; dip_on = 1'b0;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      t_por(); t_vcodes(); t_badpin(); t_badvolt(); t_pin(); t_dip(); t_wdt();
      report_and_stop();
   end
   // Watchdog against hangs
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_errors++;
      report_and_stop();
   end
endmodule : tb_top
